//--- inc/lcig_defines.svh
// Constants for the regulator control and charger input guard block
// Operation
// - Regulator turns on on 0-to-1 control edge
// - Regulator turns off on 1-to-0 control edge
// - Each regulator has own 3-bit wait field
// - Wait codes: 0 ms, then 2 ms doubling
// - Discharge path active when selected and disabled
// - Low-quiescent select puts regulator in low-Iq state
// - Power-good reads 0 below threshold
// - Unmasked regulator below threshold raises interrupt; code raises it only while the regulator is on
// - Interrupt holds until recovered/off and status read
// - Default voltage at start, software may rewrite
// - Voltage code: coarse upper, fine lower bits
// - Two-bit select sets over-voltage trip level
// - After trip, resume only below 6.0V
// - Input limit from mains-detect and charge-level
// - Lockout below 3.5V, restart 500mV above
// - Valid input powers system, else battery
`ifndef LCIG_DEFINES_SVH
`define LCIG_DEFINES_SVH
// ----------------------------------------------------------------
// Sizes and timing
// ----------------------------------------------------------------
`define LCIG_NUM_LDO 4
`define LCIG_CLK_MHZ 100
`define LCIG_WAIT_STEP_MS 2
`define LCIG_US_PER_MS 1000
`define LCIG_WAIT_UNIT_CYC (`LCIG_WAIT_STEP_MS * `LCIG_US_PER_MS * `LCIG_CLK_MHZ)
`define LCIG_VSEL_RESET 6'h2A
// ----------------------------------------------------------------
// Voltage decode, millivolts
// ----------------------------------------------------------------
`define LCIG_MV_B0 12'h258
`define LCIG_MV_B1 12'h320
`define LCIG_MV_B2 12'h3E8
`define LCIG_MV_B3 12'h4B0
`define LCIG_MV_B4 12'h640
`define LCIG_MV_B5 12'h7D0
`define LCIG_MV_B6 12'h960
`define LCIG_MV_B7 12'hC80
`define LCIG_MV_S_FINE 12'h019
`define LCIG_MV_S_MID 12'h032
`define LCIG_MV_S_WIDE 12'h064
`endif

//--- inc/lcig_pkg.sv
// Types shared by the regulator control and charger input guard block
package lcig_pkg;
  typedef enum logic [2:0] {
    LCIG_OFF = 3'b001,
    LCIG_WAIT = 3'b010,
    LCIG_ON = 3'b100
  } lcig_ldo_st_t;
  typedef enum logic [2:0] {
    LCIG_LIM_100MA = 3'b001,
    LCIG_LIM_450MA = 3'b010,
    LCIG_LIM_2A = 3'b100
  } lcig_ilim_t;
  typedef struct packed {
    logic on_ctrl;
    logic [2:0] startup_wait_sel;
    logic output_discharge_sel;
    logic low_quiescent_sel;
    logic fault_irq_unmask;
  } lcig_ldo_cfg_t;
  typedef struct packed {
    logic linreg_en;
    logic discharge_en;
    logic low_iq_en;
    logic power_good;
    logic [5:0] voltage_select;
    logic [11:0] vout_mv;
  } lcig_ldo_stat_t;
  typedef struct packed {
    logic [3:0] above_trip;
    logic above_resume;
    logic above_uvlo;
    logic above_restart;
  } lcig_chg_cmp_t;
endpackage : lcig_pkg

//--- hdl/lcig_top.sv
// Control logic for four linear regulators and the charger input guard
`timescale 1ns/100ps
`include "lcig_defines.svh"
module lcig_top import lcig_pkg::*; #(
  parameter int NUM_LDO = `LCIG_NUM_LDO,
  parameter int WAIT_UNIT_CYC = `LCIG_WAIT_UNIT_CYC,
  parameter logic [5:0] VSEL_RESET = `LCIG_VSEL_RESET
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Regulator control from software
  input wire lcig_ldo_cfg_t [NUM_LDO-1:0] ldo_cfg,
  input wire logic [NUM_LDO-1:0][5:0] voltage_select,
  input wire logic [NUM_LDO-1:0] voltage_select_wr,
  input wire logic power_good_rd,
  // Charger control
  input wire logic [1:0] overvoltage_trip_sel,
  // Analog comparators and pins, asynchronous
  input wire logic [NUM_LDO-1:0] pgood_cmp_in,
  input wire lcig_chg_cmp_t chg_cmp_in,
  input wire logic mains_detect_in,
  input wire logic charge_level_in,
  // Regulator outputs
  output lcig_ldo_stat_t [NUM_LDO-1:0] ldo_stat,
  output logic irq_request_n,
  // Charger outputs
  output logic charge_enable,
  output logic sys_from_input,
  output lcig_ilim_t input_limit
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] wait_cycles(input logic [2:0] sel);
    logic [31:0] unit;
    unit = 32'(WAIT_UNIT_CYC);
    if (sel == 3'h0) begin
      wait_cycles = 32'h0;
    end else begin
      wait_cycles = unit << (sel - 3'h1);
    end
  endfunction : wait_cycles

  function automatic logic [11:0] decode_mv(input logic [5:0] code);
    logic [11:0] base;
    logic [11:0] step;
    base = `LCIG_MV_B0;
    step = `LCIG_MV_S_FINE;
    unique case (code[5:3])
      3'h0: base = `LCIG_MV_B0;
      3'h1: base = `LCIG_MV_B1;
      3'h2: base = `LCIG_MV_B2;
      3'h3: base = `LCIG_MV_B3;
      3'h4: base = `LCIG_MV_B4;
      3'h5: base = `LCIG_MV_B5;
      3'h6: base = `LCIG_MV_B6;
      3'h7: base = `LCIG_MV_B7;
    endcase
    if (code[5:3] >= 3'h6) begin
      step = `LCIG_MV_S_WIDE;
    end else if (code[5:3] >= 3'h3) begin
      step = `LCIG_MV_S_MID;
    end
    decode_mv = 12'(base + step * {9'h0, code[2:0]});
  endfunction : decode_mv

  // ----------------------------------------------------------------
  // Input synchroniser
  // ----------------------------------------------------------------
  localparam int SW = NUM_LDO + $bits(lcig_chg_cmp_t) + 2;
  logic [SW-1:0] meta_q, meta_d;
  logic [SW-1:0] sync_q, sync_d;
  logic [NUM_LDO-1:0] pg_s;
  lcig_chg_cmp_t cmp_s;
  logic mains_s;
  logic level_s;

  always_comb begin
    meta_d = {pgood_cmp_in, chg_cmp_in, mains_detect_in, charge_level_in};
    sync_d = meta_q;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign {pg_s, cmp_s, mains_s, level_s} = sync_q;

  // ----------------------------------------------------------------
  // Regulator sequencing, fault latch and outputs
  // ----------------------------------------------------------------
  lcig_ldo_st_t st_q [NUM_LDO];
  lcig_ldo_st_t st_d [NUM_LDO];
  logic [31:0] cnt_q [NUM_LDO];
  logic [31:0] cnt_d [NUM_LDO];
  logic [NUM_LDO-1:0] on_prev_q, on_prev_d;
  logic [NUM_LDO-1:0] fault_q, fault_d;
  logic [NUM_LDO-1:0] seen_q, seen_d;
  logic [NUM_LDO-1:0][5:0] vsel_q, vsel_d;
  lcig_ldo_stat_t [NUM_LDO-1:0] stat_d;
  logic irq_n_d;

  always_comb begin
    logic rise;
    logic fall;
    logic set_f;
    rise = 1'b0;
    fall = 1'b0;
    set_f = 1'b0;
    for (int i = 0; i < NUM_LDO; i++) begin
      rise = ldo_cfg[i].on_ctrl & ~on_prev_q[i];
      fall = ~ldo_cfg[i].on_ctrl & on_prev_q[i];
      on_prev_d[i] = ldo_cfg[i].on_ctrl;
      st_d[i] = st_q[i];
      cnt_d[i] = cnt_q[i];
      unique case (st_q[i])
        LCIG_OFF: begin
          if (rise) begin
            cnt_d[i] = wait_cycles(ldo_cfg[i].startup_wait_sel);
            st_d[i] = (cnt_d[i] == 32'h0) ? LCIG_ON : LCIG_WAIT;
            cnt_d[i] = (cnt_d[i] == 32'h0) ? 32'h0 : cnt_d[i] - 32'h1;
          end
        end
        LCIG_WAIT: begin
          if (fall) begin
            st_d[i] = LCIG_OFF;
          end else if (cnt_q[i] == 32'h0) begin
            st_d[i] = LCIG_ON;
          end else begin
            cnt_d[i] = cnt_q[i] - 32'h1;
          end
        end
        LCIG_ON: begin
          if (fall) begin
            st_d[i] = LCIG_OFF;
          end
        end
        default: begin
          st_d[i] = LCIG_OFF;
        end
      endcase
      // Set wins over clear so a fault during the release is kept
      set_f = ldo_cfg[i].fault_irq_unmask & (st_q[i] == LCIG_ON) & ~pg_s[i];
      seen_d[i] = seen_q[i] | (fault_q[i] & power_good_rd);
      fault_d[i] = fault_q[i];
      if (set_f) begin
        fault_d[i] = 1'b1;
        seen_d[i] = seen_q[i] & ~(~fault_q[i]) & power_good_rd | (seen_q[i] & fault_q[i]);
      end else if (fault_q[i] & seen_d[i] & ((st_q[i] != LCIG_ON) | pg_s[i])) begin
        fault_d[i] = 1'b0;
        seen_d[i] = 1'b0;
      end
      vsel_d[i] = voltage_select_wr[i] ? voltage_select[i] : vsel_q[i];
      stat_d[i].linreg_en = (st_d[i] == LCIG_ON);
      stat_d[i].discharge_en = ldo_cfg[i].output_discharge_sel & (st_d[i] != LCIG_ON);
      stat_d[i].low_iq_en = ldo_cfg[i].low_quiescent_sel;
      stat_d[i].power_good = pg_s[i];
      stat_d[i].voltage_select = vsel_d[i];
      stat_d[i].vout_mv = decode_mv(vsel_d[i]);
    end
    irq_n_d = ~|fault_d;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < NUM_LDO; i++) begin
        st_q[i] <= LCIG_OFF;
        cnt_q[i] <= 32'h0;
        vsel_q[i] <= VSEL_RESET;
        ldo_stat[i] <= '{linreg_en: 1'b0, discharge_en: 1'b0, low_iq_en: 1'b0,
                         power_good: 1'b0, voltage_select: VSEL_RESET,
                         vout_mv: 12'h0};
      end
      on_prev_q <= '0;
      fault_q <= '0;
      seen_q <= '0;
      irq_request_n <= 1'b1;
    end else begin
      for (int i = 0; i < NUM_LDO; i++) begin
        st_q[i] <= st_d[i];
        cnt_q[i] <= cnt_d[i];
        vsel_q[i] <= vsel_d[i];
        ldo_stat[i] <= stat_d[i];
      end
      on_prev_q <= on_prev_d;
      fault_q <= fault_d;
      seen_q <= seen_d;
      irq_request_n <= irq_n_d;
    end
  end

  // ----------------------------------------------------------------
  // Charger input guard
  // ----------------------------------------------------------------
  // Lockouts start set so charging waits for a clean input after reset
  logic ovp_lock_q, ovp_lock_d;
  logic uvlo_lock_q, uvlo_lock_d;
  logic chg_en_d;
  logic sys_in_d;
  lcig_ilim_t ilim_d;

  always_comb begin
    ovp_lock_d = ovp_lock_q;
    if (cmp_s.above_trip[overvoltage_trip_sel]) begin
      ovp_lock_d = 1'b1;
    end else if (!cmp_s.above_resume) begin
      ovp_lock_d = 1'b0;
    end
    uvlo_lock_d = uvlo_lock_q;
    if (!cmp_s.above_uvlo) begin
      uvlo_lock_d = 1'b1;
    end else if (cmp_s.above_restart) begin
      uvlo_lock_d = 1'b0;
    end
    sys_in_d = ~ovp_lock_d & ~uvlo_lock_d;
    chg_en_d = sys_in_d;
    if (mains_s) begin
      ilim_d = LCIG_LIM_2A;
    end else if (level_s) begin
      ilim_d = LCIG_LIM_450MA;
    end else begin
      ilim_d = LCIG_LIM_100MA;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ovp_lock_q <= 1'b1;
      uvlo_lock_q <= 1'b1;
      charge_enable <= 1'b0;
      sys_from_input <= 1'b0;
      input_limit <= LCIG_LIM_100MA;
    end else begin
      ovp_lock_q <= ovp_lock_d;
      uvlo_lock_q <= uvlo_lock_d;
      charge_enable <= chg_en_d;
      sys_from_input <= sys_in_d;
      input_limit <= ilim_d;
    end
  end

endmodule : lcig_top

//--- sim/lcig_sva.sv
// Port checks for the regulator control and charger guard
`timescale 1ns/100ps
module lcig_sva import lcig_pkg::*; #(
  parameter int NUM_LDO = 4,
  parameter int WAIT_UNIT_CYC = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Inputs
  input wire lcig_ldo_cfg_t [NUM_LDO-1:0] ldo_cfg,
  input wire logic power_good_rd,
  input wire logic [1:0] overvoltage_trip_sel,
  input wire logic [NUM_LDO-1:0] pgood_cmp_in,
  input wire lcig_chg_cmp_t chg_cmp_in,
  // Outputs
  input wire lcig_ldo_stat_t [NUM_LDO-1:0] ldo_stat,
  input wire logic irq_request_n,
  input wire logic charge_enable,
  input wire logic sys_from_input
);
  // Only regulator 0 is tracked, to keep helper logic small
  logic on0;
  logic en0;
  logic [31:0] hi_q, hi_d;
  logic rd_q, rd_d;
  assign on0 = ldo_cfg[0].on_ctrl;
  assign en0 = ldo_stat[0].linreg_en;
  always_comb begin
    hi_d = on0 ? hi_q + 32'h1 : 32'h0;
    rd_d = irq_request_n ? 1'b0 : (rd_q | power_good_rd);
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hi_q <= 32'h0;
      rd_q <= 1'b0;
    end else begin
      hi_q <= hi_d;
      rd_q <= rd_d;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_dip0;
    (!pgood_cmp_in[0])[*4];
  endsequence
  sequence s_fault0;
    (ldo_cfg[0].fault_irq_unmask && en0 && !pgood_cmp_in[0])[*4];
  endsequence
  a_rise_turn_on: assert property ($rose(on0) && ldo_cfg[0].startup_wait_sel == 3'h0 |=> en0)
    else $error("late turn-on");
  a_off_level: assert property (!on0 |=> !en0) else $error("on while bit low");
  a_wait_count: assert property ($rose(en0) |-> hi_q ==
    (ldo_cfg[0].startup_wait_sel == 3'h0 ? 1 :
    (WAIT_UNIT_CYC << (ldo_cfg[0].startup_wait_sel - 3'h1)) + 1)) else $error("wait length");
  a_discharge_path: assert property (1'b1 |=> ldo_stat[0].discharge_en ==
    ($past(ldo_cfg[0].output_discharge_sel) && !en0)) else $error("discharge");
  a_pgood_low: assert property (s_dip0 |=> !ldo_stat[0].power_good)
    else $error("power good high");
  a_irq_set: assert property (s_fault0 |=> !irq_request_n) else $error("no irq");
  a_irq_read: assert property ($rose(irq_request_n) |-> rd_q) else $error("unread");
  a_ovp_cut: assert property (($stable(overvoltage_trip_sel) &&
    chg_cmp_in.above_trip[overvoltage_trip_sel])[*3] |=> !charge_enable) else $error("ovp");
  a_uvlo_cut: assert property ((!chg_cmp_in.above_uvlo)[*3] |=> !charge_enable)
    else $error("uvlo");
  a_sys_path: assert property (sys_from_input == charge_enable) else $error("path");
endmodule : lcig_sva

//--- sim/lcig_rail_model.sv
// Comparator model of the four regulator outputs
`timescale 1ns/100ps
module lcig_rail_model import lcig_pkg::*; (
  // Regulator side
  input wire logic clk,
  input wire lcig_ldo_stat_t [3:0] ldo_stat,
  // Bench pulls a rail under threshold
  input wire logic [3:0] droop,
  // Comparator outputs
  output logic [3:0] pgood
);
  // A rail reads good a cycle after enable and never while drooping
  initial pgood = 4'h0;
  always @(posedge clk) begin
    for (int i = 0; i < 4; i++) begin
      pgood[i] <= ldo_stat[i].linreg_en & ~droop[i];
    end
  end
endmodule : lcig_rail_model

//--- sim/tb.sv
// Self-checking bench for the regulator control and charger guard
`timescale 1ns/100ps
module tb import lcig_pkg::*;;
  typedef struct {
    logic [5:0] code;
    logic [11:0] mv;
    logic [1:0] pins;
    lcig_ilim_t lim;
  } lcig_row_t;
  localparam int UNIT = 4;
  lcig_row_t rows [4] = '{'{6'h00, 12'h258, 2'h0, LCIG_LIM_100MA},
    '{6'h1B, 12'h546, 2'h1, LCIG_LIM_450MA}, '{6'h3F, 12'hF3C, 2'h2, LCIG_LIM_2A},
    '{6'h30, 12'h960, 2'h3, LCIG_LIM_2A}};
  logic clk, resetn, rd, mains, lev, irq_n, chg_en, sys_in;
  lcig_ldo_cfg_t [3:0] cfg;
  lcig_ldo_stat_t [3:0] stat;
  logic [3:0][5:0] vsel;
  logic [3:0] vwr, droop, pg;
  logic [1:0] ovp;
  lcig_chg_cmp_t cmp;
  lcig_ilim_t lim;
  int fail_count, comparisons;
  lcig_top #(.WAIT_UNIT_CYC(UNIT)) i_lcig_top (.clk(clk), .resetn(resetn), .ldo_cfg(cfg),
    .voltage_select(vsel), .voltage_select_wr(vwr), .power_good_rd(rd),
    .overvoltage_trip_sel(ovp), .pgood_cmp_in(pg), .chg_cmp_in(cmp), .mains_detect_in(mains),
    .charge_level_in(lev), .ldo_stat(stat), .irq_request_n(irq_n), .charge_enable(chg_en),
    .sys_from_input(sys_in), .input_limit(lim));
  lcig_rail_model i_lcig_rail_model (.clk(clk), .ldo_stat(stat), .droop(droop), .pgood(pg));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  task automatic chg_after(input logic exp);
    tick(4);
    #1;
    chk(chg_en, exp);
    tick(1);
  endtask : chg_after
  // Counts edges from the rising write to the enable; bounded so a dead regulator ends the run
  task automatic turn_on(input int i, input logic [2:0] code);
    int n;
    n = 0;
    cfg[i].startup_wait_sel <= code;
    cfg[i].on_ctrl <= 1'b1;
    do begin
      tick(1);
      #1;
      n++;
    end while (stat[i].linreg_en !== 1'b1 && n < 300);
    chk(n, code == 3'h0 ? 1 : (UNIT << (code - 1)) + 1);
    if (n >= 300) summarize();
  endtask : turn_on
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    fail_count = 0;
    comparisons = 0;
    {resetn, rd, mains, lev, cfg, vsel, vwr, droop, ovp} = '0;
    cmp = '{4'h0, 1'b0, 1'b1, 1'b1};
    tick(5);
    #1;
    chk(stat[2].voltage_select, 6'h2A);
    chk(irq_n, 1'b1);
    tick(1);
    resetn <= 1'b1;
    tick(4);
    foreach (rows[r]) begin
      vsel[r] <= rows[r].code;
      vwr[r] <= 1'b1;
      {mains, lev} <= rows[r].pins;
      cfg[r].low_quiescent_sel <= rows[r].pins[0];
      tick(1);
      vwr[r] <= 1'b0;
      tick(4);
      #1;
      chk(stat[r].vout_mv, rows[r].mv);
      chk(stat[r].voltage_select, rows[r].code);
      chk(stat[r].low_iq_en, rows[r].pins[0]);
      chk(lim, rows[r].lim);
      chk(sys_in, 1'b1);
      tick(1);
    end
    for (int s = 0; s < 4; s++) begin
      ovp <= 2'(s);
      cmp.above_resume <= 1'b1;
      cmp.above_trip <= 4'hF >> (4 - s);
      chg_after(1'b1);
      cmp.above_trip <= 4'hF >> (3 - s);
      chg_after(1'b0);
      cmp.above_trip <= 4'h0;
      chg_after(1'b0);
      cmp.above_resume <= 1'b0;
      chg_after(1'b1);
    end
    {cmp.above_uvlo, cmp.above_restart} <= 2'h0;
    chg_after(1'b0);
    cmp.above_uvlo <= 1'b1;
    chg_after(1'b0);
    cmp.above_restart <= 1'b1;
    chg_after(1'b1);
    for (int c = 0; c < 8; c++) begin
      cfg[c % 4].output_discharge_sel <= 1'b1;
      tick(1);
      turn_on(c % 4, 3'(c));
      chk(stat[c % 4].discharge_en, 1'b0);
      tick(1);
      cfg[c % 4].on_ctrl <= 1'b0;
      tick(2);
      #1;
      chk(stat[c % 4].linreg_en, 1'b0);
      chk(stat[c % 4].discharge_en, 1'b1);
      tick(1);
    end
    // Abort inside the start-up wait must leave the regulator off
    cfg[1].startup_wait_sel <= 3'h3;
    cfg[1].on_ctrl <= 1'b1;
    tick(5);
    cfg[1].on_ctrl <= 1'b0;
    tick(30);
    #1;
    chk(stat[1].linreg_en, 1'b0);
    for (int i = 0; i < 4; i += 3) begin
      tick(1);
      turn_on(i, 3'h0);
      // Unmask only once the rail is good, so the latch is caused by the droop
      tick(3);
      cfg[i].fault_irq_unmask <= 1'b1;
      droop[i] <= 1'b1;
      tick(8);
      #1;
      chk(irq_n, 1'b0);
      chk(stat[i].power_good, 1'b0);
      tick(1);
      droop[i] <= 1'b0;
      tick(8);
      #1;
      chk(irq_n, 1'b0);
      tick(1);
      rd <= 1'b1;
      tick(1);
      rd <= 1'b0;
      tick(8);
      #1;
      chk(irq_n, 1'b1);
    end
    tick(1);
    turn_on(1, 3'h0);
    tick(1);
    droop[1] <= 1'b1;
    tick(8);
    #1;
    chk(irq_n, 1'b1);
    summarize();
  end
endmodule : tb
bind lcig_top lcig_sva #(.NUM_LDO(NUM_LDO), .WAIT_UNIT_CYC(WAIT_UNIT_CYC)) i_lcig_sva (
  .clk(clk), .resetn(resetn), .ldo_cfg(ldo_cfg), .power_good_rd(power_good_rd),
  .overvoltage_trip_sel(overvoltage_trip_sel), .pgood_cmp_in(pgood_cmp_in),
  .chg_cmp_in(chg_cmp_in), .ldo_stat(ldo_stat), .irq_request_n(irq_request_n),
  .charge_enable(charge_enable), .sys_from_input(sys_from_input));
